// file: src/svd_pkg.sv
// package: register map, field layout and timing of the supply-voltage detect control
package svd_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // bus geometry
    localparam int unsigned ADDR_W  = 12;
    localparam int unsigned DATA_W  = 32;

    ////////////////////////////////////////////////////////////////////////////////
    // register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_CTRL   = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h004;
    localparam logic [ADDR_W-1:0] ADDR_MASK   = 12'h008;
    localparam logic [ADDR_W-1:0] ADDR_REFEN  = 12'h00C;

    ////////////////////////////////////////////////////////////////////////////////
    // supply_monitor_control fields
    localparam int unsigned TRIP_LSB   = 0;
    localparam int unsigned TRIP_W     = 4;
    localparam int unsigned DET_EN_BIT = 4;
    localparam int unsigned REF_ST_BIT = 5;
    localparam int unsigned CTRL_W     = 8;
    localparam logic [TRIP_W-1:0] TRIP_EXT = 4'hF;
    localparam logic [TRIP_W-1:0] TRIP_RST = 4'h0;

    // status / mask layout (same layout for both)
    localparam int unsigned EVT_LOWV   = 0;
    localparam int unsigned EVT_REFRDY = 1;
    localparam int unsigned EVT_W      = 2;
    localparam logic [EVT_W-1:0] EVT_RST = 2'h0;

    // reference enable register fields
    localparam int unsigned HREF_BIT   = 0;
    localparam int unsigned LREF_BIT   = 1;
    localparam int unsigned REFEN_W    = 2;
    localparam logic [REFEN_W-1:0] REFEN_RST = 2'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // timing: clock and bandgap start-up bound
    localparam int unsigned CLK_PERIOD_PS = 25000;
    localparam int unsigned BG_START_NS   = 50000;
    localparam int unsigned BG_START_CYC  = (BG_START_NS * 1000) / CLK_PERIOD_PS;
    localparam int unsigned BG_CNT_W      = $clog2(BG_START_CYC + 1);

    // control register as one packed word
    typedef struct packed {
        logic              ref_stable;
        logic              det_en;
        logic [TRIP_W-1:0] trip;
    } svd_ctrl_s;

endpackage : svd_pkg

// file: src/svd_ctrl.sv
// supply-voltage detect control: apb registers, bandgap start-up, low-supply flag, irq
//
// Overview of operation
// - detection runs only while detector_enable (control bit 4) is set
// - trip_select in control bits 3:0 picks one of 16 thresholds
// - enabled and comparator reports supply at or below threshold sets lowvolt_flag
// - interrupt raised only when lowvolt_flag or the reference-ready flag is set together with its own mask bit
// - wake arm output lets the analog side wake the device without clock
// - software clear of lowvolt_flag ignored while supply stays at or below threshold
// - lowvolt_flag cannot set until the bandgap reference is stable
// - read-only reference_stable at control bit 5 shows bandgap stable
// - trip_select 1111 routes the external input pin to the comparator
// - enabling the detector starts an idle bandgap; detection waits its start-up
// - bandgap enable is OR of brownout, detector and both reference enables
// - bandgap counts stable no later than 50 us after start
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none

module svd_ctrl
    import svd_pkg::*;
(
    input  wire logic              i_sys_clk,
    input  wire logic              i_arst_n,
    // apb slave
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [ADDR_W-1:0] i_paddr,
    input  wire logic [DATA_W-1:0] i_pwdata,
    output logic      [DATA_W-1:0] o_prdata,
    output logic                   o_pready,
    output logic                   o_pslverr,
    // analog side and neighbours
    input  wire logic              i_cmp_low,
    input  wire logic              i_bg_stable,
    input  wire logic              i_brownout_enable,
    output logic      [TRIP_W-1:0] o_trip_select,
    output logic                   o_ext_trip_input_sel,
    output logic                   o_detector_on,
    output logic                   o_bandgap_en,
    output logic                   o_high_ref_en,
    output logic                   o_low_ref_en,
    output logic                   o_wake_arm,
    output logic                   o_irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // declarations
    localparam int unsigned SYNC_N   = 2;     // asynchronous inputs
    localparam int unsigned SYNC_CMP = 0;     // comparator slot
    localparam int unsigned SYNC_BGS = 1;     // bandgap-stable slot
    logic [SYNC_N-1:0] async_in;
    wire logic [SYNC_N-1:0] sync_q;
    logic              cmp_s2_reg;
    logic              bgs_s2_reg;
    svd_ctrl_s         ctrl_reg;
    svd_ctrl_s         ctrl_next;
    logic [EVT_W-1:0]  status_reg;
    logic [EVT_W-1:0]  status_next;
    logic [EVT_W-1:0]  mask_reg;
    logic [EVT_W-1:0]  mask_next;
    logic [REFEN_W-1:0] refen_reg;
    logic [REFEN_W-1:0] refen_next;
    logic [BG_CNT_W-1:0] bg_cnt_reg;
    logic [BG_CNT_W-1:0] bg_cnt_next;
    logic              bg_en_reg;
    logic              bg_en_next;
    logic              irq_reg;
    logic              irq_next;
    logic              wake_reg;
    logic              wake_next;
    logic              ext_sel_reg;
    logic              ext_sel_next;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic              ready_reg;
    logic              ready_next;
    logic              slverr_reg;
    logic              slverr_next;
    logic              setup;
    logic              wr_en;
    logic              addr_ok;
    logic              wr_ctrl;
    logic              wr_status;
    logic              wr_mask;
    logic              wr_refen;
    logic              lowv_evt;
    logic              refrdy_evt;

    ////////////////////////////////////////////////////////////////////////////////
    // asynchronous inputs gathered for the synchroniser, comparator in slot 0
    assign async_in = {i_bg_stable, i_cmp_low};

    // two flops per input; only the second is read, so a metastable first stage never fans out
    for (genvar g = 0; g < SYNC_N; g++) begin : g_sync
        logic stage1_reg;
        logic stage2_reg;
        // per-input flops live inside the loop
        always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
                stage1_reg <= 1'b0;
                stage2_reg <= 1'b0;
            end else begin
                stage1_reg <= async_in[g];
                stage2_reg <= stage1_reg;
            end
        end
        assign sync_q[g] = stage2_reg;
    end

    // synchronised views used by the rest of the block
    assign cmp_s2_reg = sync_q[SYNC_CMP];
    assign bgs_s2_reg = sync_q[SYNC_BGS];

    ////////////////////////////////////////////////////////////////////////////////
    // apb decode: write lands at the access edge, zero wait states
    always_comb begin
        setup   = i_psel && !i_penable;
        // ready qualifies the strobe so a stretched access phase writes once
        wr_en   = i_psel && i_penable && ready_reg && i_pwrite;
        addr_ok = (i_paddr == ADDR_CTRL) || (i_paddr == ADDR_STATUS)
               || (i_paddr == ADDR_MASK) || (i_paddr == ADDR_REFEN);
        wr_ctrl   = wr_en && (i_paddr == ADDR_CTRL);
        wr_status = wr_en && (i_paddr == ADDR_STATUS);
        wr_mask   = wr_en && (i_paddr == ADDR_MASK);
        wr_refen  = wr_en && (i_paddr == ADDR_REFEN);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // bandgap enable and start-up timer
    always_comb begin
        bg_en_next = i_brownout_enable || ctrl_reg.det_en
                  || refen_reg[HREF_BIT] || refen_reg[LREF_BIT];
        // counter saturates at the bound and restarts whenever the bandgap drops
        bg_cnt_next = bg_cnt_reg;
        if (!bg_en_reg) begin
            bg_cnt_next = '0;
        end else if (bg_cnt_reg != BG_CNT_W'(BG_START_CYC)) begin
            bg_cnt_next = bg_cnt_reg + BG_CNT_W'(1);
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            bg_en_reg  <= 1'b0;
            bg_cnt_reg <= '0;
        end else begin
            bg_en_reg  <= bg_en_next;
            bg_cnt_reg <= bg_cnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // control register: trip select, enable, read-only stable bit
    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_ctrl) begin
            ctrl_next.trip   = i_pwdata[TRIP_LSB +: TRIP_W];
            ctrl_next.det_en = i_pwdata[DET_EN_BIT];
        end
        // stable once bandgap reports it, or at the start-up bound at latest
        ctrl_next.ref_stable = bg_en_reg
            && (bgs_s2_reg || (bg_cnt_reg == BG_CNT_W'(BG_START_CYC)));
        // ext select taken from the next trip so it lines up with o_trip_select
        ext_sel_next = (ctrl_next.trip == TRIP_EXT);
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctrl_reg    <= '{ref_stable: 1'b0, det_en: 1'b0, trip: TRIP_RST};
            ext_sel_reg <= 1'b0;
        end else begin
            ctrl_reg    <= ctrl_next;
            ext_sel_reg <= ext_sel_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // mask and reference enables: plain read-write words
    always_comb begin
        // upper write bits fall away on purpose
        mask_next  = wr_mask  ? i_pwdata[EVT_W-1:0]   : mask_reg;
        refen_next = wr_refen ? i_pwdata[REFEN_W-1:0] : refen_reg;
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            mask_reg  <= EVT_RST;
            refen_reg <= REFEN_RST;
        end else begin
            mask_reg  <= mask_next;
            refen_reg <= refen_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sticky status, interrupt level and wake arm
    always_comb begin
        // flag gated by the registered stable bit, never by the raw reference input
        lowv_evt   = ctrl_reg.det_en && ctrl_reg.ref_stable && cmp_s2_reg;
        refrdy_evt = ctrl_next.ref_stable && !ctrl_reg.ref_stable;
        status_next = status_reg;
        if (wr_status) begin
            // a clear of the low flag only sticks once the supply is back up
            if (i_pwdata[EVT_LOWV] && !cmp_s2_reg) begin
                status_next[EVT_LOWV] = 1'b0;
            end
            if (i_pwdata[EVT_REFRDY]) begin
                status_next[EVT_REFRDY] = 1'b0;
            end
        end
        // set beats clear in the same cycle
        if (lowv_evt) begin
            status_next[EVT_LOWV] = 1'b1;
        end
        if (refrdy_evt) begin
            status_next[EVT_REFRDY] = 1'b1;
        end
        // irq follows status and mask in the same cycle so it never lags the flag
        irq_next   = |(status_next & mask_next);
        // analog side may wake the core from this level with the clock stopped
        wake_next  = ctrl_next.det_en && mask_next[EVT_LOWV];
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            status_reg <= EVT_RST;
            irq_reg    <= 1'b0;
            wake_reg   <= 1'b0;
        end else begin
            status_reg <= status_next;
            irq_reg    <= irq_next;
            wake_reg   <= wake_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // apb answer: ready and error during the access cycle after every setup
    always_comb begin
        // zero wait states: ready follows every setup by one cycle
        ready_next  = setup;
        slverr_next = setup && !addr_ok;   // unmapped words are refused
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ready_reg  <= 1'b0;
            slverr_reg <= 1'b0;
        end else begin
            ready_reg  <= ready_next;
            slverr_reg <= slverr_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read snapshot taken at the setup edge, held until the next setup
    always_comb begin
        rdata_next = rdata_reg;
        if (setup) begin
            rdata_next = '0;
            if (!i_pwrite) begin
                unique case (i_paddr)
                    ADDR_CTRL:   rdata_next[CTRL_W-1:0]  = {2'h0, ctrl_reg};
                    ADDR_STATUS: rdata_next[EVT_W-1:0]   = status_reg;
                    ADDR_MASK:   rdata_next[EVT_W-1:0]   = mask_reg;
                    ADDR_REFEN:  rdata_next[REFEN_W-1:0] = refen_reg;
                    default:     rdata_next = '0;
                endcase
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs, all from flops
    // analog side reads these levels directly, so none may be combinational
    assign o_prdata             = rdata_reg;
    assign o_pready             = ready_reg;
    assign o_pslverr            = slverr_reg;
    assign o_trip_select        = ctrl_reg.trip;
    assign o_ext_trip_input_sel = ext_sel_reg;
    assign o_detector_on        = ctrl_reg.det_en;
    assign o_bandgap_en         = bg_en_reg;
    assign o_high_ref_en        = refen_reg[HREF_BIT];
    assign o_low_ref_en         = refen_reg[LREF_BIT];
    assign o_wake_arm           = wake_reg;
    assign o_irq                = irq_reg;

endmodule : svd_ctrl

`default_nettype wire

// file: bench/svd_ctrl_assertions.sv
// checker: port-level assertions for the supply-voltage detect control
`timescale 1ns/100ps
`default_nettype none
module svd_ctrl_assertions
    import svd_pkg::*;
(
    input wire logic              i_sys_clk,
    input wire logic              i_arst_n,
    input wire logic              i_psel,
    input wire logic              i_penable,
    input wire logic              i_pwrite,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic              o_pready,
    input wire logic              o_pslverr,
    input wire logic              i_brownout_enable,
    input wire logic [TRIP_W-1:0] o_trip_select,
    input wire logic              o_ext_trip_input_sel,
    input wire logic              o_detector_on,
    input wire logic              o_bandgap_en,
    input wire logic              o_high_ref_en,
    input wire logic              o_low_ref_en,
    input wire logic              o_wake_arm
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_arst_n);
    ////////////////////////////////////////////////////////////////////////////////
    // apb phases
    sequence s_setup;
        i_psel && !i_penable;
    endsequence
    sequence s_unmapped;
        s_setup ##0 (i_paddr > ADDR_REFEN);
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    // bus answers
    a_ready_answer: assert property (s_setup |=> o_pready)
        else $error("no ready after setup");
    a_ready_pulse: assert property (o_pready |=> !o_pready)
        else $error("ready held too long");
    a_unmapped_err: assert property (s_unmapped |=> o_pslverr && o_pready)
        else $error("unmapped address not refused");
    // trip moves only on writes and detector turns on only on writes; ext select and bandgap follow their sources; wake needs the detector on
    a_trip_written: assert property ($changed(o_trip_select) |-> $past(i_psel && i_penable && i_pwrite))
        else $error("trip changed without write");
    a_det_written: assert property ($rose(o_detector_on) |-> $past(i_psel && i_penable && i_pwrite))
        else $error("detector on without write");
    a_ext_select: assert property (o_ext_trip_input_sel == (o_trip_select == TRIP_EXT))
        else $error("external input select wrong");
    a_bandgap_or: assert property (o_bandgap_en == $past(i_brownout_enable || o_detector_on || o_high_ref_en
        || o_low_ref_en))
        else $error("bandgap enable not or of sources");
    a_wake_needs_det: assert property (o_wake_arm |-> o_detector_on)
        else $error("wake armed while detector off");
endmodule : svd_ctrl_assertions

bind svd_ctrl svd_ctrl_assertions u_svd_ctrl_assertions (.i_sys_clk, .i_arst_n, .i_psel, .i_penable,
    .i_pwrite, .i_paddr, .o_pready, .o_pslverr, .i_brownout_enable, .o_trip_select, .o_ext_trip_input_sel,
    .o_detector_on, .o_bandgap_en, .o_high_ref_en, .o_low_ref_en, .o_wake_arm);
`default_nettype wire

// file: bench/svd_analog_model.sv
// partner: behavioural comparator and bandgap reference
`timescale 1ns/100ps
`default_nettype none
module svd_analog_model (
    input  wire logic i_bandgap_en,
    input  wire logic i_supply_low,
    input  wire logic i_slow,
    output logic      o_cmp_low,
    output logic      o_bg_stable
);
    // comparator only reports while the reference is powered
    assign o_cmp_low = i_supply_low & i_bandgap_en;
    // start-up; slow mode never reports, leaving the design's own bound
    initial o_bg_stable = 1'b0;
    always @(posedge i_bandgap_en) begin
        if (!i_slow)
            #260 o_bg_stable = i_bandgap_en;
    end
    always @(negedge i_bandgap_en) begin
        o_bg_stable = 1'b0;
    end
endmodule : svd_analog_model
`default_nettype wire

// file: bench/svd_ctrl_bench.sv
// bench: random and corner tests of the supply-voltage detect control
`timescale 1ns/100ps
`default_nettype none
module svd_ctrl_bench;
    import svd_pkg::*;
    logic clk, rst_n, psel, penable, pwrite, bo_en, sup_low, slow, cmp, bgs, er;
    logic pready, pslverr, ext_sel, det_on, bg_en, href, lref, wake, irq;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd;
    logic [TRIP_W-1:0] trip;
    int err_count, samples_checked, seed;
    svd_ctrl u_svd_ctrl (.i_sys_clk(clk), .i_arst_n(rst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_cmp_low(cmp), .i_bg_stable(bgs), .i_brownout_enable(bo_en),
        .o_trip_select(trip), .o_ext_trip_input_sel(ext_sel), .o_detector_on(det_on),
        .o_bandgap_en(bg_en), .o_high_ref_en(href), .o_low_ref_en(lref), .o_wake_arm(wake), .o_irq(irq));
    svd_analog_model u_svd_analog_model (.i_bandgap_en(bg_en), .i_supply_low(sup_low), .i_slow(slow),
        .o_cmp_low(cmp), .o_bg_stable(bgs));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // compare, bus cycle, expectation
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // ready sampled at a rising edge; only the watchdog bounds the wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    function automatic logic [31:0] ctl(input logic [3:0] t, input logic e, input logic s);
        return {26'h0, s, e, t};
    endfunction : ctl
    task give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : give_verdict
    // watchdog
    initial begin
        #(25 * 9000);
        err_count++;
        give_verdict();
    end
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        seed = 9194;
        {err_count, samples_checked} = 0;
        {rst_n, psel, penable, pwrite, bo_en, sup_low, slow, paddr, pwdata} = '0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 12'(i * 4), $random(seed));
            chk("reset word", rd, 32'h0);
            chk("slave error", {31'h0, er}, {31'h0, i == 4});
        end
        $display("test reset done");
        for (int t = 0; t < 16; t++) begin
            apb(1'b1, ADDR_CTRL, ($random(seed) & 32'hFFFF_FFC0) | 32'(t));
            apb(1'b0, ADDR_CTRL, $random(seed));
            @(negedge clk);
            chk("trip", rd, ctl(4'(t), 1'b0, 1'b0));
            chk("ext select", {31'h0, ext_sel}, {31'h0, t == 15});
        end
        $display("test trip codes done");
        slow <= 1'b1;
        sup_low <= 1'b1;
        apb(1'b1, ADDR_CTRL, 32'h03);
        apb(1'b1, ADDR_CTRL, 32'h13);
        repeat (40) @(posedge clk);
        chk("bandgap on", {31'h0, bg_en}, 32'h1);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("flag blocked", rd, 32'h0);
        repeat (2000) @(posedge clk);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk("stable bound", rd, ctl(4'h3, 1'b1, 1'b1));
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("flag set", rd, 32'h3);
        chk("irq masked", {31'h0, irq}, 32'h0);
        apb(1'b1, ADDR_MASK, 32'h1);
        bo_en <= 1'b1;
        @(negedge clk);
        chk("irq", {30'h0, wake, irq}, 32'h3);
        // detector off, bandgap held by brownout: only the clear guard keeps the flag
        apb(1'b1, ADDR_CTRL, 32'h03);
        apb(1'b1, ADDR_STATUS, 32'h3);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("clear refused", rd, 32'h1);
        sup_low <= 1'b0;
        bo_en <= 1'b0;
        apb(1'b1, ADDR_MASK, 32'h0);
        apb(1'b1, ADDR_STATUS, 32'h1);
        apb(1'b0, ADDR_STATUS, 32'h0);
        @(negedge clk);
        chk("flag cleared", {rd[30:0], irq}, 32'h0);
        $display("test low supply done");
        slow <= 1'b0;
        sup_low <= 1'b1;
        apb(1'b1, ADDR_CTRL, 32'h0);
        apb(1'b1, ADDR_REFEN, 32'h3);
        for (int n = 0; n < 30 && !rd[REF_ST_BIT]; n++)
            apb(1'b0, ADDR_CTRL, 32'h0);
        chk("refs stable", rd, ctl(4'h0, 1'b0, 1'b1));
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("detector off", rd, 32'h2);
        apb(1'b1, ADDR_REFEN, 32'h0);
        bo_en <= 1'b1;
        repeat (3) @(posedge clk);
        chk("brownout source", {29'h0, href, lref, bg_en}, 32'h1);
        $display("test references done");
        give_verdict();
    end
endmodule : svd_ctrl_bench
`default_nettype wire
